// ---- include/hbgfs_pkg.sv ----
// Constants, enumerations and carrier types of the H-bridge gate fault supervisor.
// Assumes a single 25 MHz core clock and analog comparators that deliver levels.
//
// What this block does
// - Grounded strap selects 6/12.5 mA, high-side monitoring.
// - Floating strap selects 100/200 mA, high-side monitoring.
// - Strap to regulator: 25/50 mA, high-side monitoring off.
// - Resistor straps select 12.5, 25, 150 mA levels.
// - Dead time before opposite FET of a leg.
// - Control inputs are deglitched before use.
// - Overcurrent needs drain-source trip for deglitch time.
// - Overcurrent turns bridge off, fault low, retry later.
// - Fault released after retry; repeats while overcurrent persists.
// - Sense input over threshold also trips overcurrent.
// - Supply undervoltage stops bridge, pump, analog regulator.
// - Pump undervoltage stops bridge until rail recovers.
// - Sleep stops both regulators; supply undervoltage and overtemperature stop analog.
package hbgfs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned DEAD_NS = 150;
  localparam int unsigned DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DGL_NS = 200;
  localparam int unsigned DGL_CYC = (DGL_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OCP_NS = 4000;
  localparam int unsigned OCP_CYC = (OCP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RETRY_NS = 4000000;
  localparam int unsigned RETRY_CYC = RETRY_NS * CLK_MHZ / 1000;
  localparam int unsigned DEAD_W = 3;
  localparam int unsigned DGL_W = 4;
  localparam int unsigned OCP_W = 8;
  localparam int unsigned RETRY_W = 20;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_MASK = 12'h004;
  localparam logic [11:0] ADDR_STATE = 12'h008;
  localparam logic [11:0] ADDR_CTRL = 12'h00c;
  localparam int unsigned EVT_W = 4;
  localparam int unsigned EVT_OCP = 0;
  localparam int unsigned EVT_SUPPLY_UNDERVOLTAGE_LOCKOUT = 1;
  localparam int unsigned EVT_PUMP_UNDERVOLTAGE = 2;
  localparam int unsigned EVT_TSD = 3;
  localparam int unsigned CTRL_BDIS = 0;
  localparam logic [EVT_W-1:0] MASK_RST = 4'h0;
  localparam logic CTRL_BDIS_RST = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    STRAP_GND = 3'h0,
    STRAP_33K = 3'h1,
    STRAP_200K = 3'h2,
    STRAP_OPEN = 3'h3,
    STRAP_68K = 3'h4,
    STRAP_AREG = 3'h5
  } hbgfs_strap_t;

  typedef enum logic [2:0] {
    LVL_6MA = 3'h0,
    LVL_12MA5 = 3'h1,
    LVL_25MA = 3'h2,
    LVL_100MA = 3'h3,
    LVL_150MA = 3'h4
  } hbgfs_level_t;

  typedef enum logic [2:0] {
    SUP_RUN = 3'b001,
    SUP_RETRY = 3'b010,
    SUP_HOLD = 3'b100
  } hbgfs_sup_t;

  typedef struct packed {
    logic sleep_request_n;
    logic in1;
    logic in2;
    logic [3:0] vds_over;
    logic sense_positive_over;
    logic supply_uv;
    logic pump_uv;
    logic overtemp;
    hbgfs_strap_t drive_strength_strap;
  } hbgfs_pins_t;

  typedef struct packed {
    logic [1:0] high_side_gate;
    logic [1:0] low_side_gate;
  } hbgfs_gates_t;

endpackage : hbgfs_pkg

// ---- hdl/hbgfs_supervisor.sv ----
// H-bridge gate drive control and fault supervisor with APB registers.
// Assumes pins arrive asynchronously and APB shares core_clk_i.
`timescale 1ns/1ps
module hbgfs_supervisor import hbgfs_pkg::*; #(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC,
  parameter int unsigned OCP_CYCLES = OCP_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Pins and comparators
  input wire hbgfs_pins_t pins_i,
  // Bridge and supplies
  output hbgfs_gates_t gates_o,
  output logic fault_out_n_o,
  output logic pump_en_o,
  output logic analog_reg_en_o,
  output logic digital_reg_en_o,
  output hbgfs_level_t drive_level_o,
  output logic hs_ocp_monitor_o,
  output logic irq_o,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (RETRY_CYCLES < 2 || RETRY_CYCLES >= (1 << RETRY_W)) begin : g_bad_retry
    $error("RETRY_CYCLES out of range");
  end
  if (OCP_CYCLES < 1 || OCP_CYCLES >= (1 << OCP_W)) begin : g_bad_ocp
    $error("OCP_CYCLES out of range");
  end
  if (DEAD_CYC < 2 || DEAD_CYC >= (1 << DEAD_W)) begin : g_bad_dead
    $error("DEAD_CYC out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    hbgfs_pins_t s1;
    hbgfs_pins_t s2;
    logic [2:0] flt;
    logic [2:0][DGL_W-1:0] dgl_cnt;
    logic [2:0] hold_prev;
    logic [1:0] boot;
    logic strap_ok;
    hbgfs_level_t level;
    logic hs_mon;
    hbgfs_gates_t gates;
    logic [1:0][DEAD_W-1:0] dead;
    hbgfs_sup_t sup;
    logic [OCP_W-1:0] ocp_cnt;
    logic [RETRY_W-1:0] retry_cnt;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] mask;
    logic bdis;
    logic fault_n;
    logic pump_en;
    logic areg_en;
    logic dreg_en;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } hbgfs_state_t;

  localparam hbgfs_state_t ST_RST = '{
    s1: '0, s2: '0, flt: 3'h0, dgl_cnt: '0, hold_prev: 3'h0, boot: 2'h0,
    strap_ok: 1'b0, level: LVL_6MA, hs_mon: 1'b0, gates: '0, dead: '0,
    sup: SUP_RUN, ocp_cnt: '0, retry_cnt: '0, status: '0, mask: MASK_RST,
    bdis: CTRL_BDIS_RST, fault_n: 1'b1, pump_en: 1'b0, areg_en: 1'b0,
    dreg_en: 1'b0, irq: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0
  };

  hbgfs_state_t st;
  hbgfs_state_t nxt;
  logic [2:0] raw;
  logic sleep;
  logic hold;
  logic [3:0] mon;
  logic ocp_raw;
  logic ocp_trip;
  logic allow;
  logic [1:0] want_hs;
  logic [1:0] want_ls;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] clr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt = st;
    raw = {st.s2.sleep_request_n, st.s2.in1, st.s2.in2};
    sleep = ~st.flt[2];
    hold = st.s2.supply_uv | st.s2.pump_uv | st.s2.overtemp;
    ocp_trip = 1'b0;
    clr = '0;
    nxt.s1 = pins_i;
    nxt.s2 = st.s1;

    // Input filter: a new level is taken only after it holds steady.
    for (int i = 0; i < 3; i++) begin
      if (raw[i] == st.flt[i]) begin
        nxt.dgl_cnt[i] = '0;
      end else if (st.dgl_cnt[i] == DGL_W'(DGL_CYC - 1)) begin
        nxt.flt[i] = raw[i];
        nxt.dgl_cnt[i] = '0;
      end else begin
        nxt.dgl_cnt[i] = st.dgl_cnt[i] + 1'b1;
      end
    end

    // Strap capture once the pin synchroniser holds a valid level.
    if (!st.strap_ok) begin
      if (st.boot == 2'h2) begin
        nxt.strap_ok = 1'b1;
        nxt.hs_mon = 1'b1;
        unique case (st.s2.drive_strength_strap)
          STRAP_GND: nxt.level = LVL_6MA;
          STRAP_33K: nxt.level = LVL_12MA5;
          STRAP_200K: nxt.level = LVL_25MA;
          STRAP_OPEN: nxt.level = LVL_100MA;
          STRAP_68K: nxt.level = LVL_150MA;
          STRAP_AREG: begin
            nxt.level = LVL_25MA;
            nxt.hs_mon = 1'b0;
          end
          default: nxt.level = LVL_100MA;
        endcase
      end else begin
        nxt.boot = st.boot + 2'h1;
      end
    end

    // Overcurrent sources: drain-source only on conducting FETs.
    mon = {st.gates.low_side_gate[1] & st.s2.vds_over[3],
           st.gates.high_side_gate[1] & st.s2.vds_over[2] & st.hs_mon,
           st.gates.low_side_gate[0] & st.s2.vds_over[1],
           st.gates.high_side_gate[0] & st.s2.vds_over[0] & st.hs_mon};
    ocp_raw = (|mon) | st.s2.sense_positive_over;

    // Supervisor.
    unique case (st.sup)
      SUP_RUN: begin
        nxt.retry_cnt = '0;
        if (hold) begin
          nxt.sup = SUP_HOLD;
          nxt.ocp_cnt = '0;
        end else if (!ocp_raw) begin
          nxt.ocp_cnt = '0;
        end else if (st.ocp_cnt == OCP_W'(OCP_CYCLES - 1)) begin
          ocp_trip = 1'b1;
          nxt.sup = SUP_RETRY;
          nxt.ocp_cnt = '0;
        end else begin
          nxt.ocp_cnt = st.ocp_cnt + 1'b1;
        end
      end
      SUP_RETRY: begin
        if (hold) begin
          nxt.sup = SUP_HOLD;
          nxt.retry_cnt = '0;
        end else if (st.retry_cnt == RETRY_W'(RETRY_CYCLES - 1)) begin
          nxt.sup = SUP_RUN;
          nxt.retry_cnt = '0;
        end else begin
          nxt.retry_cnt = st.retry_cnt + 1'b1;
        end
      end
      SUP_HOLD: begin
        if (!hold) begin
          nxt.sup = SUP_RUN;
        end
      end
      default: nxt.sup = SUP_HOLD;
    endcase
    nxt.fault_n = ~(hold | (nxt.sup != SUP_RUN));

    // Leg drive with dead time on every turn-off.
    allow = (nxt.sup == SUP_RUN) & ~hold & ~sleep & ~st.bdis & st.strap_ok;
    want_hs[0] = allow & st.flt[1] & ~st.flt[0];
    want_ls[0] = allow & st.flt[0];
    want_hs[1] = allow & st.flt[0] & ~st.flt[1];
    want_ls[1] = allow & st.flt[1];
    for (int l = 0; l < 2; l++) begin
      if ((st.gates.high_side_gate[l] & ~want_hs[l]) |
          (st.gates.low_side_gate[l] & ~want_ls[l])) begin
        nxt.gates.high_side_gate[l] = 1'b0;
        nxt.gates.low_side_gate[l] = 1'b0;
        nxt.dead[l] = DEAD_W'(DEAD_CYC - 1);
      end else if (st.dead[l] != '0) begin
        nxt.dead[l] = st.dead[l] - 1'b1;
      end else begin
        nxt.gates.high_side_gate[l] = want_hs[l];
        nxt.gates.low_side_gate[l] = want_ls[l];
      end
    end

    // Supply enables.
    nxt.pump_en = ~sleep & ~st.s2.supply_uv & ~st.s2.overtemp;
    nxt.areg_en = ~sleep & ~st.s2.supply_uv & ~st.s2.overtemp;
    nxt.dreg_en = ~sleep;

    // Events.
    evt = '0;
    evt[EVT_OCP] = ocp_trip;
    evt[EVT_SUPPLY_UNDERVOLTAGE_LOCKOUT] = st.s2.supply_uv & ~st.hold_prev[0];
    evt[EVT_PUMP_UNDERVOLTAGE] = st.s2.pump_uv & ~st.hold_prev[1];
    evt[EVT_TSD] = st.s2.overtemp & ~st.hold_prev[2];
    nxt.hold_prev = {st.s2.overtemp, st.s2.pump_uv, st.s2.supply_uv};

    // APB: one wait state, effects at the completing edge.
    nxt.pready = 1'b0;
    nxt.pslverr = 1'b0;
    if (psel_i && penable_i && !st.pready) begin
      nxt.pready = 1'b1;
      nxt.prdata = 32'h0;
      unique case (paddr_i)
        ADDR_STATUS: nxt.prdata = {28'h0, st.status};
        ADDR_MASK: nxt.prdata = {28'h0, st.mask};
        ADDR_STATE: nxt.prdata = {19'h0, st.gates, st.sup, ~st.fault_n, sleep,
                                  st.hs_mon, st.level};
        ADDR_CTRL: nxt.prdata = {31'h0, st.bdis};
        default: nxt.pslverr = 1'b1;
      endcase
      if (pwrite_i) begin
        nxt.prdata = 32'h0;
      end
    end
    if (psel_i && penable_i && st.pready && !st.pslverr) begin
      if (pwrite_i) begin
        if (paddr_i == ADDR_MASK) begin
          nxt.mask = pwdata_i[EVT_W-1:0];
        end
        if (paddr_i == ADDR_CTRL) begin
          nxt.bdis = pwdata_i[CTRL_BDIS];
        end
      end else if (paddr_i == ADDR_STATUS) begin
        clr = st.prdata[EVT_W-1:0];
      end
    end
    nxt.status = (st.status & ~clr) | evt;
    nxt.irq = |(st.status & st.mask);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= ST_RST;
    end else begin
      st <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign gates_o = st.gates;
  assign fault_out_n_o = st.fault_n;
  assign pump_en_o = st.pump_en;
  assign analog_reg_en_o = st.areg_en;
  assign digital_reg_en_o = st.dreg_en;
  assign drive_level_o = st.level;
  assign hs_ocp_monitor_o = st.hs_mon;
  assign irq_o = st.irq;
  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_strap_ground: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ($rose(st.strap_ok) && $past(st.s2.drive_strength_strap) == STRAP_GND)
    |-> (drive_level_o == LVL_6MA && hs_ocp_monitor_o))
    else $error("grounded strap decoded wrongly");

  a_strap_open: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ($rose(st.strap_ok) && $past(st.s2.drive_strength_strap) == STRAP_OPEN)
    |-> (drive_level_o == LVL_100MA && hs_ocp_monitor_o))
    else $error("open strap decoded wrongly");

  a_strap_areg: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ($rose(st.strap_ok) && $past(st.s2.drive_strength_strap) == STRAP_AREG)
    |-> (drive_level_o == LVL_25MA && !hs_ocp_monitor_o))
    else $error("regulator strap decoded wrongly");

  a_strap_resistor: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ($rose(st.strap_ok) && $past(st.s2.drive_strength_strap) == STRAP_68K)
    |-> (drive_level_o == LVL_150MA && hs_ocp_monitor_o))
    else $error("resistor strap decoded wrongly");

  a_leg_deadtime: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(gates_o.high_side_gate[0]) |-> !gates_o.low_side_gate[0] [*4])
    else $error("low side on inside dead time");

  a_leg_exclusive: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(|(gates_o.high_side_gate & gates_o.low_side_gate)))
    else $error("both FETs of a leg on");

  a_input_glitch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $changed(st.flt[1]) |-> $past(st.dgl_cnt[1]) == DGL_W'(DGL_CYC - 1))
    else $error("input taken before filter time");

  a_ocp_deglitch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(st.sup == SUP_RETRY) |-> $past(st.ocp_cnt) == OCP_W'(OCP_CYCLES - 1))
    else $error("overcurrent declared early");

  a_fault_gates: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st.sup != SUP_RUN) |-> (gates_o == '0 && !fault_out_n_o))
    else $error("bridge on or fault high during fault");

  a_retry_release: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st.sup == SUP_RETRY && st.retry_cnt == RETRY_W'(RETRY_CYCLES - 1) && !hold)
    |=> (st.sup == SUP_RUN && fault_out_n_o))
    else $error("fault not released after retry");

  a_sense_path: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (st.sup == SUP_RUN && !hold && st.s2.sense_positive_over)
    |=> (st.ocp_cnt != '0 || st.sup != SUP_RUN))
    else $error("sense overcurrent not counted");

  a_supply_undervoltage_lockout_shut: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st.s2.supply_uv |=> (!pump_en_o && !analog_reg_en_o && !fault_out_n_o && gates_o == '0))
    else $error("undervoltage response missing");

  a_pump_undervoltage_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st.s2.pump_uv |=> (gates_o == '0 && !fault_out_n_o))
    else $error("pump undervoltage response missing");

  a_sleep_regs: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !st.flt[2] |=> (!digital_reg_en_o && !analog_reg_en_o && gates_o == '0))
    else $error("regulators on in sleep");

endmodule : hbgfs_supervisor

// ---- verification/hbgfs_bridge_model.sv ----
// Behavioural model of the external FET bridge and its supplies.
// Assumes the bench steers the load and supply faults through the control inputs.
`timescale 1ns/1ps
module hbgfs_bridge_model import hbgfs_pkg::*; (
  // Gate drive from the supervisor
  input wire hbgfs_gates_t gates_i,
  // Load and supply conditions
  input wire logic overload_i,
  input wire logic sense_hi_i,
  input wire logic supply_low_i,
  input wire logic pump_low_i,
  // Comparator levels back to the supervisor
  output logic [3:0] vds_over_o,
  output logic sense_over_o,
  output logic supply_uv_o,
  output logic pump_uv_o
);
  // A shorted load drops voltage only across FETs that conduct.
  assign vds_over_o = {gates_i.low_side_gate[1], gates_i.high_side_gate[1],
    gates_i.low_side_gate[0], gates_i.high_side_gate[0]} & {4{overload_i}};
  // Sense current flows only while some FET conducts.
  assign sense_over_o = sense_hi_i & (|gates_i);
  assign supply_uv_o = supply_low_i;
  assign pump_uv_o = pump_low_i;
endmodule : hbgfs_bridge_model

// ---- verification/hbgfs_supervisor_tb.sv ----
// Self-checking bench for the gate fault supervisor.
// Assumes the bridge model on the pins and APB access to the registers.
`timescale 1ns/1ps
module hbgfs_supervisor_tb import hbgfs_pkg::*;;
  localparam int unsigned RTY = 20;
  typedef struct {string nm; logic [19:0] ex; logic [19:0] mk;} hbgfs_note_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sleep_n = 0, in1 = 0, in2 = 0, otemp = 0, overload = 0, sense_hi = 0;
  logic supply_low = 0, pump_low = 0, psel = 0, penable = 0, pwrite = 0, meas_stb = 0;
  logic [2:0] strap = 3'h3;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [19:0] meas_v = '0;
  logic [3:0] vds;
  logic sense_over, supply_uv, pump_uv, fault_n, pump_en, areg_en, dreg_en, irq, pready, pslverr;
  logic [31:0] prdata;
  hbgfs_pins_t pins;
  hbgfs_gates_t gates;
  hbgfs_note_t notes[$];
  hbgfs_note_t cur;
  logic [19:0] obs;
  logic [2:0] lvl;
  logic hsm;
  logic [2:0] lvl_exp [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h2};
  logic hs_exp [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [3:0] gmap [4] = '{4'h0, 4'h9, 4'h6, 4'h3};
  int bad_count = 0;
  int compares = 0;
  int seed = 32'h5829b37b;
  int n;
  int r;

  always #20 core_clk = ~core_clk;
  assign pins = '{sleep_request_n: sleep_n, in1: in1, in2: in2, vds_over: vds,
    sense_positive_over: sense_over, supply_uv: supply_uv, pump_uv: pump_uv,
    overtemp: otemp, drive_strength_strap: hbgfs_strap_t'(strap)};

  hbgfs_supervisor #(.RETRY_CYCLES(RTY), .OCP_CYCLES(3)) i_hbgfs_supervisor (
    .core_clk_i(core_clk), .rst_i(rst), .pins_i(pins), .gates_o(gates),
    .fault_out_n_o(fault_n), .pump_en_o(pump_en), .analog_reg_en_o(areg_en),
    .digital_reg_en_o(dreg_en), .drive_level_o(lvl), .hs_ocp_monitor_o(hsm), .irq_o(irq),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

  hbgfs_bridge_model i_hbgfs_bridge_model (
    .gates_i(gates), .overload_i(overload), .sense_hi_i(sense_hi),
    .supply_low_i(supply_low), .pump_low_i(pump_low), .vds_over_o(vds),
    .sense_over_o(sense_over), .supply_uv_o(supply_uv), .pump_uv_o(pump_uv));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task conclude;
    $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  function logic [19:0] ex(input logic ir, fn, pe, ae, de, er, input logic [12:0] d);
    return {ir, fn, pe, ae, de, er, 1'b0, d};
  endfunction : ex

  function logic [12:0] st(input logic [3:0] g, input logic [2:0] s, input logic f);
    return {g, s, f, 1'b0, 1'b1, 3'h3};
  endfunction : st

  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      bad_count++;
      conclude();
    end
  endtask : apb

  task rd(input logic [11:0] a, input logic [19:0] e, input logic [19:0] m, input string nm);
    notes.push_back('{nm, e, m});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task meas(input string nm, input logic [19:0] e, input logic [19:0] v);
    notes.push_back('{nm, e, 20'hfffff});
    @(posedge core_clk);
    meas_v <= v;
    meas_stb <= 1'b1;
    @(posedge core_clk);
    meas_stb <= 1'b0;
  endtask : meas

  task wait_fault(input logic v, input int lim);
    n = 0;
    while (fault_n !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_fault

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if ((psel && penable && pready === 1'b1 && !pwrite) || meas_stb) begin
      cur = notes.pop_front();
      obs = meas_stb ? meas_v : {irq, fault_n, pump_en, areg_en, dreg_en, pslverr, 1'b0,
        prdata[12:0]};
      compares++;
      if ((obs & cur.mk) !== (cur.ex & cur.mk)) begin
        $display("ERROR %s expected %h seen %h", cur.nm, cur.ex & cur.mk, obs & cur.mk);
        bad_count++;
      end
    end
  end

  initial begin
    cyc(20000);
    bad_count++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(12);
    rst <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      @(posedge core_clk);
      strap <= (k < 6) ? k[2:0] : 3'h3;
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(6);
      if (k < 6) begin
        rd(ADDR_STATE, {16'h0, hs_exp[k], lvl_exp[k]}, 20'hf, "strap");
        meas("pins", 20'({hs_exp[k], lvl_exp[k]}), 20'({hsm, lvl}));
      end
    end
    $display("Test strap decode done");
    rd(ADDR_STATE, 20'h40010, 20'h78010, "asleep");
    @(posedge core_clk);
    sleep_n <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      {in1, in2} <= k[1:0];
      cyc(16);
      rd(ADDR_STATE, ex(0, 1, 1, 1, 1, 0, st(gmap[k], 3'h1, 0)), '1, "drive");
      r = 1 + ($random(seed) & 3);
      @(posedge core_clk);
      {in1, in2} <= ~k[1:0];
      cyc(r);
      {in1, in2} <= k[1:0];
      cyc(12);
      rd(ADDR_STATE, ex(0, 1, 1, 1, 1, 0, st(gmap[k], 3'h1, 0)), '1, "glitch");
    end
    $display("Test drive and deglitch done");
    @(posedge core_clk);
    {in1, in2} <= 2'b10;
    cyc(14);
    {in1, in2} <= 2'b01;
    wait_fault(1'b1, 0);
    while (gates.high_side_gate[0] !== 1'b0 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 40) begin
      bad_count++;
      conclude();
    end
    n = 0;
    while (gates.low_side_gate[0] !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    meas("dead time", 20'(DEAD_CYC), 20'(n));
    @(posedge core_clk);
    overload <= 1'b1;
    cyc(2);
    overload <= 1'b0;
    cyc(12);
    rd(ADDR_STATE, ex(0, 1, 1, 1, 1, 0, st(4'h9, 3'h1, 0)), '1, "short trip");
    @(posedge core_clk);
    overload <= 1'b1;
    cyc(12);
    rd(ADDR_STATE, ex(0, 0, 1, 1, 1, 0, st(4'h0, 3'h2, 1)), '1, "ocp trip");
    wait_fault(1'b1, 40);
    meas("retry release", 20'h1, 20'(n < 40));
    wait_fault(1'b0, 30);
    meas("retrip", 20'h1, 20'(n < 30));
    @(posedge core_clk);
    overload <= 1'b0;
    cyc(RTY + 20);
    rd(ADDR_STATE, ex(0, 1, 1, 1, 1, 0, st(4'h9, 3'h1, 0)), '1, "ocp resume");
    rd(ADDR_STATUS, ex(0, 1, 1, 1, 1, 0, 13'h1), '1, "status ocp");
    rd(ADDR_STATUS, ex(0, 1, 1, 1, 1, 0, 13'h0), '1, "status cleared");
    $display("Test overcurrent done");
    @(posedge core_clk);
    sense_hi <= 1'b1;
    cyc(12);
    rd(ADDR_STATE, ex(0, 0, 1, 1, 1, 0, st(4'h0, 3'h2, 1)), '1, "sense trip");
    sense_hi <= 1'b0;
    cyc(RTY + 20);
    rd(ADDR_STATUS, ex(0, 1, 1, 1, 1, 0, 13'h1), '1, "sense status");
    $display("Test sense done");
    apb(1'b1, ADDR_MASK, 32'h2);
    rd(ADDR_MASK, ex(0, 1, 1, 1, 1, 0, 13'h2), '1, "mask");
    @(posedge core_clk);
    supply_low <= 1'b1;
    cyc(8);
    rd(ADDR_STATE, ex(1, 0, 0, 0, 1, 0, st(4'h0, 3'h4, 1)), '1, "supply uv");
    supply_low <= 1'b0;
    cyc(16);
    rd(ADDR_STATUS, ex(1, 1, 1, 1, 1, 0, 13'h2), '1, "uv status");
    rd(ADDR_STATE, ex(0, 1, 1, 1, 1, 0, st(4'h9, 3'h1, 0)), '1, "uv resume");
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      pump_low <= (k == 0);
      otemp <= (k == 1);
      cyc(8);
      rd(ADDR_STATE, ex(0, 0, k == 0, k == 0, 1, 0, st(4'h0, 3'h4, 1)), '1, "uv ot");
      pump_low <= 1'b0;
      otemp <= 1'b0;
      cyc(16);
      rd(ADDR_STATE, ex(0, 1, 1, 1, 1, 0, st(4'h9, 3'h1, 0)), '1, "resume");
    end
    rd(ADDR_STATUS, ex(0, 1, 1, 1, 1, 0, 13'hc), '1, "masked status");
    apb(1'b1, ADDR_CTRL, 32'h1);
    cyc(4);
    rd(ADDR_STATE, ex(0, 1, 1, 1, 1, 0, st(4'h0, 3'h1, 0)), '1, "bridge off");
    apb(1'b1, ADDR_CTRL, 32'h0);
    rd(12'h010, ex(0, 1, 1, 1, 1, 1, 13'h0), '1, "unmapped");
    @(posedge core_clk);
    sleep_n <= 1'b0;
    cyc(16);
    rd(ADDR_STATE, 20'h40010, 20'h79e10, "sleep again");
    $display("Test faults and registers done");
    conclude();
  end
endmodule : hbgfs_supervisor_tb
